// ---- core/srap_spi_port.sv ----
`default_nettype none
// Contract
// - datagram bit 39 set means write, clear means read request.
// - a full reply shifts out during every datagram.
// - after a read request, reply data is the register it addressed.
// - after a write, reply data echoes that write's data.
// - read requests modify nothing except that a global state read clears the error and reset flags; data ignored, only the address kept.
// - reply bits 39 to 32 carry the status byte.
// - status is latched at each access end and sent next transfer.
// - status bits 7..0: stops right/left, position, velocity, standstill, stall, error, reset.
// - error and reset bits stay set until the global state register is read.
// - register values sit right aligned in the 32 data bits.
// - input sampled on rising clock, output updated after falling, select low.
// - both directions send the most significant bit first.
// - bits beyond forty leave serial out forty clocks later, for daisy chains.
// - select rising takes the last forty shifted bits as the command.
// - serial inputs and driver enable are filtered against pulses under 20 ns.
// - bus runs in mode 3, clock idles high, capture on rising edge.
// - each datagram is one address byte and four data bytes.
module srap_spi_port
   import srap_pkg::*;
#(
   parameter int          FIFO_DEPTH   = CMD_FIFO_DEPTH,
   parameter logic [6:0]  GSTATE_ADDR  = GLOBAL_STATE_ADDR
) (
   input  wire logic              ref_clk_i,
   input  wire logic              rst_i,
   input  wire logic              sck_i,
   input  wire logic              select_n_i,
   input  wire logic              serial_in_i,
   input  wire logic              driver_enable_n_i,
   output logic                   serial_out_o,
   output logic                   serial_out_oe_o,
   output logic                   driver_enable_n_o,
   input  wire logic              stop_right_i,
   input  wire logic              stop_left_i,
   input  wire logic              position_reached_i,
   input  wire logic              velocity_reached_i,
   input  wire logic              standstill_i,
   input  wire logic              stall_detect_flag_i,
   input  wire logic              driver_error_i,
   input  wire logic              reset_event_i,
   output logic                   cmd_valid_o,
   input  wire logic              cmd_ready_i,
   output logic [ADDR_W-1:0]      cmd_addr_o,
   output logic [DATA_W-1:0]      cmd_data_o,
   output logic                   cmd_drop_o,
   output logic                   rd_req_o,
   output logic [ADDR_W-1:0]      rd_addr_o,
   input  wire logic [DATA_W-1:0] rd_data_i,
   output logic [STATUS_W-1:0]    status_o
);
   typedef enum logic [0:0] {
      SRAP_IDLE,
      SRAP_FRAME
   } srap_state_type;

   srap_state_type          state_reg;
   logic [3:0]              filt;
   logic                    sck_f;
   logic                    sel_n_f;
   logic                    sdi_f;
   logic                    sck_prev_reg;
   logic                    sel_prev_reg;
   logic                    sel_fall;
   logic                    sel_rise;
   logic                    sck_rise;
   logic                    sck_fall;
   logic [FRAME_BITS-1:0]   shift_reg;
   logic [DATA_W-1:0]       reply_reg;
   logic                    reply_from_read_reg;
   logic                    drv_err_reg;
   logic                    reset_seen_reg;
   logic                    pend_valid_reg;
   logic [CMD_W-1:0]        pend_reg;
   logic                    fifo_in_ready;
   logic [CMD_W-1:0]        fifo_out;
   logic                    cmd_write;
   logic [ADDR_W-1:0]       cmd_addr;
   logic                    gstate_read;
   logic                    frame_end;

   function automatic logic [STATUS_W-1:0] pack_status(
      input logic err,
      input logic rst_seen
   );
      logic [STATUS_W-1:0] s;
      s                    = '0;
      s[STAT_STOP_RIGHT]   = stop_right_i;
      s[STAT_STOP_LEFT]    = stop_left_i;
      s[STAT_POS_REACHED]  = position_reached_i;
      s[STAT_VEL_REACHED]  = velocity_reached_i;
      s[STAT_STANDSTILL]   = standstill_i;
      s[STAT_STALL]        = stall_detect_flag_i;
      s[STAT_DRIVER_ERROR] = err;
      s[STAT_RESET_SEEN]   = rst_seen;
      pack_status          = s;
   endfunction : pack_status

   // ==========================================================================
   // input synchronisers and glitch filters
   srap_in_filter #(
      .WIDTH      (4),
      .STABLE_CYC (FILT_CYCLES),
      .RESET_VAL  (4'hf)
   ) u_filter (
      .ref_clk_i  (ref_clk_i),
      .rst_i      (rst_i),
      .raw_i      ({driver_enable_n_i, sck_i, serial_in_i, select_n_i}),
      .filt_o     (filt)
   );

   assign sel_n_f = filt[0];
   assign sdi_f   = filt[1];
   assign sck_f   = filt[2];

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         driver_enable_n_o <= 1'b1;
      end else begin
         driver_enable_n_o <= filt[3];
      end
   end

   // ==========================================================================
   // edge detection on the filtered bus signals
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         sck_prev_reg <= 1'b1;
      end else begin
         sck_prev_reg <= sck_f;
      end
   end

   // ==========================================================================
   // select edge detection
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         sel_prev_reg <= 1'b1;
      end else begin
         sel_prev_reg <= sel_n_f;
      end
   end

   assign sel_fall = sel_prev_reg & ~sel_n_f;
   assign sel_rise = ~sel_prev_reg & sel_n_f;
   assign sck_rise = ~sck_prev_reg & sck_f & ~sel_n_f;
   assign sck_fall = sck_prev_reg & ~sck_f & ~sel_n_f;

   // ==========================================================================
   // command decode of the last forty bits
   assign cmd_write   = shift_reg[WRITE_SELECT_POS];
   assign cmd_addr    = shift_reg[ADDR_MSB:ADDR_LSB];
   // a select rise closes a frame only after a select fall
   assign frame_end   = sel_rise & (state_reg == SRAP_FRAME);
   assign gstate_read = frame_end & ~cmd_write & (cmd_addr == GSTATE_ADDR);

   // ==========================================================================
   // frame state
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg <= SRAP_IDLE;
      end else begin
         case (state_reg)
            SRAP_IDLE: begin
               if (sel_fall) begin
                  state_reg <= SRAP_FRAME;
               end
            end
            SRAP_FRAME: begin
               if (sel_rise) begin
                  state_reg <= SRAP_IDLE;
               end
            end
            default: begin
               state_reg <= SRAP_IDLE;
            end
         endcase
      end
   end

   // ==========================================================================
   // shift register: loaded with the reply, then shifted msb first
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         shift_reg <= '0;
      end else if (sel_fall) begin
         shift_reg <= {status_o, reply_from_read_reg ? rd_data_i : reply_reg};
      end else if (sck_rise) begin
         shift_reg <= {shift_reg[FRAME_BITS-2:0], sdi_f};
      end
   end

   // ==========================================================================
   // serial output, driven only inside a frame
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         serial_out_oe_o <= 1'b0;
      end else begin
         serial_out_oe_o <= ~sel_n_f;
      end
   end

   // ==========================================================================
   // serial data, first bit from the status byte as the shift register loads
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         serial_out_o <= 1'b0;
      end else if (sel_fall) begin
         serial_out_o <= status_o[STATUS_W-1];
      end else if (sck_fall) begin
         serial_out_o <= shift_reg[FRAME_BITS-1];
      end
   end

   // ==========================================================================
   // reply data for the following frame
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         reply_from_read_reg <= 1'b0;
      end else if (frame_end) begin
         reply_from_read_reg <= ~cmd_write;
      end
   end

   // ==========================================================================
   // write data kept for the echo in the next reply
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         reply_reg <= '0;
      end else if (frame_end && cmd_write) begin
         reply_reg <= shift_reg[DATA_W-1:0];
      end
   end

   // ==========================================================================
   // read request towards the register file
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rd_req_o <= 1'b0;
      end else begin
         rd_req_o <= frame_end & ~cmd_write;
      end
   end

   // ==========================================================================
   // address of the last read request
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rd_addr_o <= '0;
      end else if (frame_end && !cmd_write) begin
         rd_addr_o <= cmd_addr;
      end
   end

   // ==========================================================================
   // sticky error and reset flags, a new event wins over the clear
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         drv_err_reg <= 1'b0;
      end else if (driver_error_i) begin
         drv_err_reg <= 1'b1;
      end else if (gstate_read) begin
         drv_err_reg <= 1'b0;
      end
   end

   // ==========================================================================
   // reset occurred flag, set again by every reset event
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         reset_seen_reg <= 1'b1;
      end else if (reset_event_i) begin
         reset_seen_reg <= 1'b1;
      end else if (gstate_read) begin
         reset_seen_reg <= 1'b0;
      end
   end

   // ==========================================================================
   // status latched at the end of each access
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         status_o <= STATUS_RESET;
      end else if (frame_end) begin
         status_o <= pack_status(drv_err_reg, reset_seen_reg);
      end
   end

   // ==========================================================================
   // write commands wait here until the fifo takes them
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pend_valid_reg <= 1'b0;
         pend_reg       <= '0;
      end else begin
         if (pend_valid_reg && fifo_in_ready) begin
            pend_valid_reg <= 1'b0;
         end
         if (frame_end && cmd_write && (!pend_valid_reg || fifo_in_ready)) begin
            pend_valid_reg <= 1'b1;
            pend_reg       <= shift_reg[CMD_W-1:0];
         end
      end
   end

   // ==========================================================================
   // a write that finds pending slot and fifo full is lost and flagged
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cmd_drop_o <= 1'b0;
      end else begin
         cmd_drop_o <= frame_end & cmd_write & pend_valid_reg & ~fifo_in_ready;
      end
   end

   // ==========================================================================
   // command fifo towards the register file
   srap_fifo #(
      .WIDTH       (CMD_W),
      .DEPTH       (FIFO_DEPTH)
   ) u_cmd_fifo (
      .ref_clk_i   (ref_clk_i),
      .rst_i       (rst_i),
      .in_valid_i  (pend_valid_reg),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (pend_reg),
      .out_valid_o (cmd_valid_o),
      .out_ready_i (cmd_ready_i),
      .out_data_o  (fifo_out)
   );

   assign cmd_addr_o = fifo_out[CMD_W-1:DATA_W];
   assign cmd_data_o = fifo_out[DATA_W-1:0];
endmodule : srap_spi_port
`default_nettype wire

// ---- core/srap_pkg.sv ----
`default_nettype none
// ==========================================================================
// shared constants of the serial register access port
package srap_pkg;
   localparam int          FRAME_BITS         = 40;
   localparam int          ADDR_W             = 7;
   localparam int          DATA_W             = 32;
   localparam int          STATUS_W           = 8;
   localparam int          CMD_W              = ADDR_W + DATA_W;
   localparam int          WRITE_SELECT_POS   = 39;
   localparam int          ADDR_MSB           = 38;
   localparam int          ADDR_LSB           = 32;
   localparam int          STAT_STOP_RIGHT    = 7;
   localparam int          STAT_STOP_LEFT     = 6;
   localparam int          STAT_POS_REACHED   = 5;
   localparam int          STAT_VEL_REACHED   = 4;
   localparam int          STAT_STANDSTILL    = 3;
   localparam int          STAT_STALL         = 2;
   localparam int          STAT_DRIVER_ERROR  = 1;
   localparam int          STAT_RESET_SEEN    = 0;
   localparam logic [7:0]  STATUS_RESET       = 8'h01;
   localparam logic [6:0]  GLOBAL_STATE_ADDR  = 7'h01;
   localparam int          CLK_PERIOD_NS      = 25;
   localparam int          FILT_TIME_NS       = 20;
   localparam int          FILT_CYCLES_RAW    = (FILT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          FILT_CYCLES        = (FILT_CYCLES_RAW < 1) ? 1 : FILT_CYCLES_RAW;
   localparam int          CMD_FIFO_DEPTH     = 8;
endpackage : srap_pkg
`default_nettype wire

// ---- core/srap_in_filter.sv ----
`default_nettype none
// ==========================================================================
// two-flop synchroniser followed by a per-bit stability filter
module srap_in_filter
   import srap_pkg::*;
#(
   parameter int              WIDTH       = 4,
   parameter int              STABLE_CYC  = 1,
   parameter logic [WIDTH-1:0] RESET_VAL  = '1
) (
   input  wire logic             ref_clk_i,
   input  wire logic             rst_i,
   input  wire logic [WIDTH-1:0] raw_i,
   output logic      [WIDTH-1:0] filt_o
);
   localparam int CW = $clog2(STABLE_CYC + 1);

   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;
   logic [CW-1:0]    cnt_reg [WIDTH];

   // ==========================================================================
   // synchroniser
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_reg <= RESET_VAL;
         sync_reg <= RESET_VAL;
      end else begin
         meta_reg <= raw_i;
         sync_reg <= meta_reg;
      end
   end

   // ==========================================================================
   // accept a new level only after it held for the filter time
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         filt_o <= RESET_VAL;
         for (int i = 0; i < WIDTH; i++) begin
            cnt_reg[i] <= '0;
         end
      end else begin
         for (int i = 0; i < WIDTH; i++) begin
            if (sync_reg[i] == filt_o[i]) begin
               cnt_reg[i] <= '0;
            end else if (cnt_reg[i] >= CW'(STABLE_CYC)) begin
               filt_o[i]  <= sync_reg[i];
               cnt_reg[i] <= '0;
            end else begin
               cnt_reg[i] <= cnt_reg[i] + CW'(1);
            end
         end
      end
   end
endmodule : srap_in_filter
`default_nettype wire

// ---- core/srap_fifo.sv ----
`default_nettype none
// ==========================================================================
// command fifo with a registered output word
module srap_fifo
   import srap_pkg::*;
#(
   parameter int WIDTH = 39,
   parameter int DEPTH = 8
) (
   input  wire logic             ref_clk_i,
   input  wire logic             rst_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [PW-1:0]    wr_ptr_reg;
   logic [PW-1:0]    rd_ptr_reg;
   logic [CW-1:0]    count_reg;
   logic             push;
   logic             pop;

   function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
      ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
   endfunction : ptr_inc

   assign in_ready_o = (count_reg != CW'(DEPTH));
   assign push       = in_valid_i & in_ready_o;
   assign pop        = (count_reg != '0) & (~out_valid_o | out_ready_i);

   // ==========================================================================
   // storage
   always_ff @(posedge ref_clk_i) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data_i;
      end
   end

   // ==========================================================================
   // pointers and fill level
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= ptr_inc(wr_ptr_reg);
         end
         if (pop) begin
            rd_ptr_reg <= ptr_inc(rd_ptr_reg);
         end
         count_reg <= count_reg + CW'(push) - CW'(pop);
      end
   end

   // ==========================================================================
   // output word
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         out_valid_o <= 1'b0;
         out_data_o  <= '0;
      end else if (pop) begin
         out_valid_o <= 1'b1;
         out_data_o  <= mem_reg[rd_ptr_reg];
      end else if (out_ready_i) begin
         out_valid_o <= 1'b0;
      end
   end
endmodule : srap_fifo
`default_nettype wire

// ---- test/srap_spi_port_chk.sv ----
`default_nettype none
// ==========================================================================
// port checker
module srap_spi_port_chk
   import srap_pkg::*;
(
   input wire logic                ref_clk_i,
   input wire logic                rst_i,
   input wire logic                select_n_i,
   input wire logic                driver_enable_n_i,
   input wire logic                serial_out_oe_o,
   input wire logic                driver_enable_n_o,
   input wire logic                stop_right_i,
   input wire logic                stop_left_i,
   input wire logic                position_reached_i,
   input wire logic                velocity_reached_i,
   input wire logic                standstill_i,
   input wire logic                stall_detect_flag_i,
   input wire logic                cmd_valid_o,
   input wire logic                cmd_ready_i,
   input wire logic [ADDR_W-1:0]   cmd_addr_o,
   input wire logic [DATA_W-1:0]   cmd_data_o,
   input wire logic                cmd_drop_o,
   input wire logic                rd_req_o,
   input wire logic [ADDR_W-1:0]   rd_addr_o,
   input wire logic [STATUS_W-1:0] status_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);
   oe_idle_a: assert property (select_n_i [*8] |-> !serial_out_oe_o)
      else $error("serial out driven while deselected");
   oe_frame_a: assert property (!select_n_i [*8] |-> serial_out_oe_o)
      else $error("serial out not driven in frame");
   rd_pulse_a: assert property (rd_req_o |-> select_n_i ##1 !rd_req_o)
      else $error("read request outside frame end");
   rd_addr_a: assert property ($changed(rd_addr_o) |-> rd_req_o)
      else $error("read address moved without request");
   cmd_hold_a: assert property (cmd_valid_o && !cmd_ready_i |=>
      cmd_valid_o && $stable(cmd_addr_o) && $stable(cmd_data_o))
      else $error("write command not held");
   drop_full_a: assert property (cmd_drop_o |-> cmd_valid_o ##1 !cmd_drop_o)
      else $error("drop without full queue");
   status_latch_a: assert property ($changed(status_o) |-> select_n_i)
      else $error("status changed inside frame");
   status_src_a: assert property ($changed(status_o) |-> status_o[7:2] ==
      $past({stop_right_i, stop_left_i, position_reached_i, velocity_reached_i,
       standstill_i, stall_detect_flag_i}))
      else $error("status bits out of order");
   enable_filt_a: assert property ($changed(driver_enable_n_o) |->
      driver_enable_n_o == $past(driver_enable_n_i) &&
      driver_enable_n_o == $past(driver_enable_n_i, 2))
      else $error("enable passed a short pulse");
endmodule : srap_spi_port_chk

bind srap_spi_port srap_spi_port_chk i_chk (.ref_clk_i, .rst_i, .select_n_i,
   .driver_enable_n_i, .serial_out_oe_o, .driver_enable_n_o, .stop_right_i, .stop_left_i,
   .position_reached_i, .velocity_reached_i, .standstill_i, .stall_detect_flag_i,
   .cmd_valid_o, .cmd_ready_i, .cmd_addr_o, .cmd_data_o, .cmd_drop_o, .rd_req_o,
   .rd_addr_o, .status_o);
`default_nettype wire

// ---- test/srap_spi_master.sv ----
`default_nettype none
// ==========================================================================
// bus master model, mode 3, sck period 8 ref clocks
module srap_spi_master (
   input  wire logic ref_clk_i,
   input  wire logic sdo_line_i,
   output logic      sck_o,
   output logic      select_n_o,
   output logic      serial_in_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      sck_o = 1'b1;
      select_n_o = 1'b1;
      serial_in_o = 1'b1;
   end
   task automatic frame(input logic [63:0] tx, input int nbits, output logic [63:0] rx);
      rx = '0;
      select_n_o <= 1'b0;
      repeat (8) @(posedge ref_clk_i);
      for (int i = 0; i < nbits; i++) begin
         sck_o <= 1'b0;
         serial_in_o <= tx[nbits-1-i];
         repeat (4) @(posedge ref_clk_i);
         sck_o <= 1'b1;
         repeat (3) @(posedge ref_clk_i);
         @(negedge ref_clk_i) rx = {rx[62:0], sdo_line_i};
         @(posedge ref_clk_i);
      end
      select_n_o <= 1'b1;
      serial_in_o <= ~serial_in_o;
      repeat (12) @(posedge ref_clk_i);
   endtask : frame
   task automatic glitch();
      select_n_o <= 1'b0;
      @(posedge ref_clk_i);
      select_n_o <= 1'b1;
      @(posedge ref_clk_i);
   endtask : glitch
endmodule : srap_spi_master
`default_nettype wire

// ---- test/tb_srap_spi_port.sv ----
`default_nettype none
// ==========================================================================
// testbench
module tb_srap_spi_port
   import srap_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk_i, rst_i, sck_i, select_n_i, serial_in_i, driver_enable_n_i;
   logic        serial_out_o, serial_out_oe_o, driver_enable_n_o, float_bit, sdo_line;
   logic        driver_error_i, reset_event_i, cmd_valid_o, cmd_ready_i, cmd_drop_o;
   logic        rd_req_o, seen;
   logic [7:2]  stat_in;
   logic [6:0]  cmd_addr_o, rd_addr_o;
   logic [31:0] cmd_data_o, rd_data_i;
   logic [7:0]  status_o;
   logic [63:0] rx;
   logic [38:0] cmdq[$];
   int          fail_count, compares, drops, cycles;

   srap_spi_port i_dut (.ref_clk_i, .rst_i, .sck_i, .select_n_i, .serial_in_i,
      .driver_enable_n_i, .serial_out_o, .serial_out_oe_o, .driver_enable_n_o,
      .stop_right_i(stat_in[7]), .stop_left_i(stat_in[6]), .position_reached_i(stat_in[5]),
      .velocity_reached_i(stat_in[4]), .standstill_i(stat_in[3]),
      .stall_detect_flag_i(stat_in[2]), .driver_error_i, .reset_event_i, .cmd_valid_o,
      .cmd_ready_i, .cmd_addr_o, .cmd_data_o, .cmd_drop_o, .rd_req_o, .rd_addr_o,
      .rd_data_i, .status_o);
   srap_spi_master i_master (.ref_clk_i, .sdo_line_i(sdo_line), .sck_o(sck_i),
      .select_n_o(select_n_i), .serial_in_o(serial_in_i));

   // released line shows a toggling level
   assign sdo_line = serial_out_oe_o ? serial_out_o : float_bit;

   function automatic logic [31:0] reg_val(input logic [6:0] a);
      return {25'h1a5a5a5, a};
   endfunction : reg_val

   initial begin
      ref_clk_i = 1'b0;
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end

   always @(posedge ref_clk_i) begin
      float_bit <= ~float_bit;
      rd_data_i <= reg_val(rd_addr_o);
      if (cmd_valid_o === 1'b1 && cmd_ready_i === 1'b1)
         cmdq.push_back({cmd_addr_o, cmd_data_o});
      if (cmd_drop_o === 1'b1)
         drops++;
      cycles++;
      if (cycles == 40000) begin
         fail_count++;
         results();
      end
   end

   task automatic check(input string name, input logic [63:0] got, input logic [63:0] exp);
      compares++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
         fail_count++;
      end
   endtask : check

   task automatic xfer(input logic w, input logic [6:0] a, input logic [31:0] d);
      i_master.frame({24'h0, {w, 7'h0} + {1'b0, a}, d}, 40, rx);
   endtask : xfer

   task automatic results();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : results

   initial begin
      rst_i = 1'b1;
      driver_enable_n_i = 1'b1;
      stat_in = 6'h0;
      driver_error_i = 1'b0;
      reset_event_i = 1'b0;
      cmd_ready_i = 1'b1;
      rd_data_i = 32'h0;
      float_bit = 1'b0;
      repeat (5) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      repeat (8) @(posedge ref_clk_i);
      check("status reset", 64'(status_o), 64'h01);
      check("enable reset", 64'(driver_enable_n_o), 64'h1);
      stat_in <= 6'h2d;
      xfer(1'b0, 7'h21, 32'hffffffff);
      check("first status", rx[39:32], 64'h01);
      check("status latch", 64'(status_o), 64'hb5);
      xfer(1'b0, 7'h22, 32'h0);
      check("read reply", rx[39:0], {24'h0, 8'hb5, reg_val(7'h21)});
      xfer(1'b1, 7'h27, 32'h00abcdef);
      check("read reply 2", rx[31:0], 64'(reg_val(7'h22)));
      xfer(1'b1, 7'h27, 32'h00123456);
      check("write echo", rx[31:0], 64'h00abcdef);
      xfer(1'b0, 7'h27, 32'h0);
      check("write echo 2", rx[31:0], 64'h00123456);
      check("cmd count", 64'(cmdq.size()), 64'h2);
      check("cmd 0", 64'(cmdq[0]), {25'h0, 7'h27, 32'h00abcdef});
      check("cmd 1", 64'(cmdq[1]), {25'h0, 7'h27, 32'h00123456});
      for (int k = 0; k < 6; k++) begin
         stat_in <= 6'(1 << k);
         xfer(1'b0, 7'h05, 32'h0);
         check("status bit", 64'(status_o[7:2]), 64'(1 << k));
      end
      driver_error_i <= 1'b1;
      @(posedge ref_clk_i);
      driver_error_i <= 1'b0;
      xfer(1'b0, 7'h05, 32'h0);
      check("sticky set", 64'(status_o[1:0]), 64'h3);
      xfer(1'b0, GLOBAL_STATE_ADDR, 32'h0);
      check("sticky held", 64'(status_o[1:0]), 64'h3);
      xfer(1'b0, 7'h05, 32'h0);
      check("sticky clear", 64'(status_o[1:0]), 64'h0);
      reset_event_i <= 1'b1;
      @(posedge ref_clk_i);
      reset_event_i <= 1'b0;
      xfer(1'b0, 7'h05, 32'h0);
      check("reset event", 64'(status_o[1:0]), 64'h1);
      cmdq.delete();
      i_master.frame({16'h0, 8'hc5, 8'hb0, 32'hcafe0001}, 48, rx);
      check("chain out", rx[7:0], 64'hc5);
      check("last forty", 64'(cmdq[0]), {25'h0, 7'h30, 32'hcafe0001});
      cmdq.delete();
      drops = 0;
      cmd_ready_i <= 1'b0;
      for (int i = 0; i < 11; i++)
         xfer(1'b1, 7'(7'h40 + i), 32'(i));
      check("drops", 64'(drops), 64'h1);
      cmd_ready_i <= 1'b1;
      repeat (20) @(posedge ref_clk_i);
      check("drained", 64'(cmdq.size()), 64'ha);
      check("order", 64'(cmdq[9]), {25'h0, 7'h49, 32'h9});
      i_master.glitch();
      seen = 1'b0;
      repeat (10) @(negedge ref_clk_i) seen = seen | serial_out_oe_o;
      check("select glitch", 64'(seen), 64'h0);
      @(posedge ref_clk_i);
      driver_enable_n_i <= 1'b0;
      repeat (8) @(posedge ref_clk_i);
      check("enable on", 64'(driver_enable_n_o), 64'h0);
      driver_enable_n_i <= 1'b1;
      @(posedge ref_clk_i);
      driver_enable_n_i <= 1'b0;
      seen = 1'b0;
      repeat (8) @(negedge ref_clk_i) seen = seen | driver_enable_n_o;
      check("enable glitch", 64'(seen), 64'h0);
      results();
   end
endmodule : tb_srap_spi_port
`default_nettype wire
